// ### common/rpu_regs.vh
// constants of the region protection unit: register selects, fields, reset values, codes
`ifndef RPU_REGS_VH
`define RPU_REGS_VH
`define RPU_NUM_REGIONS 8
// register selects on the system control coprocessor port
`define RPU_SEL_CTRL 4'h1
`define RPU_SEL_DCACHE 4'h2
`define RPU_SEL_ICACHE 4'h3
`define RPU_SEL_BUF 4'h4
`define RPU_SEL_DPERM 4'h5
`define RPU_SEL_IPERM 4'h6
`define RPU_SEL_REGION 4'h7
// base-and-size register fields
`define RPU_BASE_HI 31
`define RPU_BASE_LO 12
`define RPU_SIZE_HI 5
`define RPU_SIZE_LO 1
`define RPU_EN_BIT 0
`define RPU_REGION_RESET 32'h00000000
`define RPU_CTRL_RESET 32'h00000000
`define RPU_ATTR_RESET 8'h00
`define RPU_PERM_RESET 32'h00000000
// control register protection enable bit
`define RPU_CTRL_PU_BIT 0
// size codes
`define RPU_SIZE_MIN 5'h0b
`define RPU_SIZE_MAX 5'h1f
// permission codes
`define RPU_AP_NONE 4'h0
`define RPU_AP_PRIV 4'h1
`define RPU_AP_PRIV_URO 4'h2
`define RPU_AP_FULL 4'h3
`define RPU_AP_PRIV_RO 4'h5
`define RPU_AP_RO 4'h6
// multi-word split granule, address bit of 4KB
`define RPU_PAGE_BIT 12
`endif

// ### src/rpu_region_match.v
// one protection region comparator
module rpu_region_match (
   input wire [31:0] region_in, // base-and-size register value
   input wire [31:0] addr_in, // access address
   output wire hit_out // region enabled and address inside
);
`include "rpu_regs.vh"
   wire [4:0] size_code;
   wire [31:0] mask;
   assign size_code = region_in[`RPU_SIZE_HI:`RPU_SIZE_LO];
   // size decode: 2^(code+1) bytes, keep address bits at and above code+1
   assign mask = (size_code == `RPU_SIZE_MAX) ? 32'h00000000 :
      (32'hffffffff << ({27'h0, size_code} + 32'h1));
   assign hit_out = region_in[`RPU_EN_BIT] &&
      ((addr_in & mask) == ({region_in[`RPU_BASE_HI:`RPU_BASE_LO], 12'h000} & mask));
endmodule

// ### src/rpu_perm_check.v
// permission decode of one four-bit access permission code
module rpu_perm_check (
   input wire [3:0] perm_in, // permission code of winning region
   input wire priv_in, // access in privileged mode
   input wire write_in, // access is a write
   output reg allow_out // access permitted
);
`include "rpu_regs.vh"
   // code decode, user and privileged rights
   always @* begin
      case (perm_in)
         `RPU_AP_NONE: allow_out = 1'b0;
         `RPU_AP_PRIV: allow_out = priv_in;
         `RPU_AP_PRIV_URO: allow_out = priv_in | ~write_in;
         `RPU_AP_FULL: allow_out = 1'b1;
         `RPU_AP_PRIV_RO: allow_out = priv_in & ~write_in;
         `RPU_AP_RO: allow_out = ~write_in;
         default: allow_out = 1'b0;
      endcase
   end
endmodule

// ### src/rpu_top.v
// region protection unit: region registers, lookup and abort generation
// Contract
// - eight independently programmable regions of variable size
// - checking enabled only while control bit 0 is set
// - disabled: fetches noncachable, data noncachable and nonbufferable
// - base in [31:12], size in [5:1], enable in bit 0
// - reset clears every region enable bit
// - size code b01011 is 4KB, each step doubles, b11111 4GB
// - per-region cachable, bufferable for data, read/write permissions
// - failed permission gives prefetch abort or data abort
// - cachable and bufferable bits select one of four configurations
// - highest numbered matching region wins, region 7 highest
// - no enabled region matched while enabled aborts the access
// - code b0010 privileged full, user read; b0001 privileged only
// - multi-word beats entering a new 4KB page are flagged; every beat checked on its own address
module rpu_top #(
   parameter NREG = 8
) (
   input wire clk_in, // core clock
   input wire rst_in, // synchronous reset, active high
   input wire cp_wr_in, // coprocessor register write strobe
   input wire cp_rd_in, // coprocessor register read strobe
   input wire [3:0] cp_sel_in, // coprocessor register select
   input wire [2:0] cp_region_in, // region number for region registers
   input wire [31:0] cp_wdata_in, // coprocessor write data
   output reg [31:0] cp_rdata_out, // coprocessor read data
   input wire i_req_in, // instruction fetch valid
   input wire [31:0] i_addr_in, // instruction fetch address
   input wire i_priv_in, // fetch in privileged mode
   input wire d_req_in, // data access valid
   input wire [31:0] d_addr_in, // data address
   input wire d_write_in, // data access is a write
   input wire d_priv_in, // data access in privileged mode
   input wire d_multi_in, // data access is a multi-word transfer beat
   output reg i_cachable_out, // fetch may be cached
   output reg i_abort_out, // prefetch abort
   output reg d_cachable_out, // data may be cached
   output reg d_bufferable_out, // data may be write-buffered
   output reg [1:0] d_cfg_out, // data cache and write buffer configuration
   output reg d_abort_out, // data abort
   output reg d_split_out, // multi-word beat crossed a 4KB page
   output reg pu_enabled_out // protection currently enabled
);
`include "rpu_regs.vh"

   // register map on the coprocessor port, picked by cp_sel_in:
   //    1  control; bit 0 turns checking on, other bits are stored only
   //    2  data cachable flags, bit n for region n
   //    3  fetch cachable flags, bit n for region n
   //    4  data bufferable flags, bit n for region n; fetches have none
   //    5  data permission codes, region n in bits 4n+3 down to 4n
   //    6  fetch permission codes, same packing as the data codes
   //    7  base-and-size of the region named by cp_region_in
   //    other selects: writes are dropped, reads return zero
   // base-and-size word:
   //    31..12  base address, a multiple of the region size
   //    11..6   unused, kept at zero
   //    5..1    size code, region spans 2^(code+1) bytes
   //    0       region enable, cleared by reset
   // size codes: 11 is 4KB, 12 is 8KB, each step doubles, 31 covers all 4GB
   // permission codes, privileged / user:
   //    0  none / none
   //    1  read-write / none
   //    2  read-write / read
   //    3  read-write / read-write
   //    5  read / none
   //    6  read / read
   //    others deny both, the safe reading of a code we do not expect
   // lookup, per path and per cycle:
   //    every enabled region compares the address against its masked base
   //    the highest numbered hit wins, region 7 over region 0
   //    no hit while checking is on aborts a valid request
   //    the winner's permission code, the mode and the direction decide
   //    fetches are judged as reads against their own code and flags
   //    data cachable and bufferable pick one of four {C,B} configurations
   //    with checking off nothing aborts and nothing is cached or buffered
   //    multi-word data beats that enter a new 4KB page are flagged; every
   //    beat is still judged on its own address
   // timing: writes count for lookups from the next cycle; read data and
   // lookup verdicts come out of flops at the same edge that takes the request
   // limitation: size codes below 11 and misaligned bases are not caught;
   // they only give a smaller or odd mask, so software has to avoid them

   reg [31:0] region_ff [0:NREG-1];

   // control, attribute and permission registers
   reg [31:0] ctrl_ff;
   reg [NREG-1:0] dcache_ff;
   reg [NREG-1:0] icache_ff;
   reg [NREG-1:0] buf_ff;
   reg [31:0] dperm_ff;
   reg [31:0] iperm_ff;

   // previous data beat, for page crossings
   reg [31:0] last_d_addr_ff;
   reg last_multi_ff;

   // comparator hits, verdicts and the enable
   wire [NREG-1:0] i_hit;
   wire [NREG-1:0] d_hit;
   wire i_allow;
   wire d_allow;
   wire pu_on;

   // next values of the registered outputs
   reg nxt_i_abort;
   reg nxt_i_cachable;
   reg nxt_d_abort;
   reg nxt_d_cachable;
   reg nxt_d_bufferable;
   reg [1:0] nxt_d_cfg;
   wire nxt_d_split;
   integer k;

   // attribute flags widened to a full read-back word
   function [31:0] rpu_widen;
      input [NREG-1:0] flags;
      begin
         rpu_widen = {{(32-NREG){1'b0}}, flags};
      end
   endfunction

   // winning region index, highest set bit; used for both paths
   function [3:0] rpu_prio;
      input [NREG-1:0] hits;
      integer j;
      begin
         rpu_prio = 4'h8;
         for (j = 0; j < NREG; j = j + 1) begin
            if (hits[j]) begin
               rpu_prio = j[3:0];
            end
         end
      end
   endfunction

   // 4-bit permission field of a region out of a packed word
   function [3:0] rpu_perm;
      input [31:0] word;
      input [2:0] idx;
      begin
         rpu_perm = word[idx*4 +: 4];
      end
   endfunction

   assign pu_on = ctrl_ff[`RPU_CTRL_PU_BIT];

   // one comparator per region and path
   genvar g;
   generate
      for (g = 0; g < NREG; g = g + 1) begin : gen_region
         rpu_region_match u_i_match (
            .region_in(region_ff[g]),
            .addr_in(i_addr_in),
            .hit_out(i_hit[g])
         );
         rpu_region_match u_d_match (
            .region_in(region_ff[g]),
            .addr_in(d_addr_in),
            .hit_out(d_hit[g])
         );
      end
   endgenerate

   wire [3:0] i_win;
   wire [3:0] d_win;
   wire i_any;
   wire d_any;
   assign i_win = rpu_prio(i_hit);
   assign d_win = rpu_prio(d_hit);
   assign i_any = |i_hit;
   assign d_any = |d_hit;

   rpu_perm_check u_i_perm (
      .perm_in(i_any ? rpu_perm(iperm_ff, i_win[2:0]) : `RPU_AP_NONE),
      .priv_in(i_priv_in),
      .write_in(1'b0),
      .allow_out(i_allow)
   );
   rpu_perm_check u_d_perm (
      .perm_in(d_any ? rpu_perm(dperm_ff, d_win[2:0]) : `RPU_AP_NONE),
      .priv_in(d_priv_in),
      .write_in(d_write_in),
      .allow_out(d_allow)
   );

   // register writes from the coprocessor port
   always @(posedge clk_in) begin
      if (rst_in) begin
         for (k = 0; k < NREG; k = k + 1) begin
            region_ff[k] <= `RPU_REGION_RESET;
         end
         ctrl_ff <= `RPU_CTRL_RESET;
         dcache_ff <= {NREG{1'b0}};
         icache_ff <= {NREG{1'b0}};
         buf_ff <= {NREG{1'b0}};
         dperm_ff <= `RPU_PERM_RESET;
         iperm_ff <= `RPU_PERM_RESET;
      end else if (cp_wr_in) begin
         case (cp_sel_in)
            `RPU_SEL_CTRL: ctrl_ff <= cp_wdata_in;
            `RPU_SEL_DCACHE: dcache_ff <= cp_wdata_in[NREG-1:0];
            `RPU_SEL_ICACHE: icache_ff <= cp_wdata_in[NREG-1:0];
            `RPU_SEL_BUF: buf_ff <= cp_wdata_in[NREG-1:0];
            `RPU_SEL_DPERM: dperm_ff <= cp_wdata_in;
            `RPU_SEL_IPERM: iperm_ff <= cp_wdata_in;
            // unused bits 11:6 stored as zero
            `RPU_SEL_REGION: region_ff[cp_region_in] <=
               {cp_wdata_in[31:12], 6'h00, cp_wdata_in[5:0]};
            default: ctrl_ff <= ctrl_ff;
         endcase
      end
   end

   // register read-back, registered
   always @(posedge clk_in) begin
      if (rst_in) begin
         cp_rdata_out <= 32'h00000000;
      end else if (cp_rd_in) begin
         case (cp_sel_in)
            `RPU_SEL_CTRL: cp_rdata_out <= ctrl_ff;
            `RPU_SEL_DCACHE: cp_rdata_out <= rpu_widen(dcache_ff);
            `RPU_SEL_ICACHE: cp_rdata_out <= rpu_widen(icache_ff);
            `RPU_SEL_BUF: cp_rdata_out <= rpu_widen(buf_ff);
            `RPU_SEL_DPERM: cp_rdata_out <= dperm_ff;
            `RPU_SEL_IPERM: cp_rdata_out <= iperm_ff;
            `RPU_SEL_REGION: cp_rdata_out <= region_ff[cp_region_in];
            default: cp_rdata_out <= 32'h00000000;
         endcase
      end
   end

   // multi-word tracking: address and multi flag of the last data access taken, multi or not
   always @(posedge clk_in) begin
      if (rst_in) begin
         last_d_addr_ff <= 32'h00000000;
         last_multi_ff <= 1'b0;
      end else if (d_req_in) begin
         last_d_addr_ff <= d_addr_in;
         last_multi_ff <= d_multi_in;
      end
   end

   // next lookup results; bypass values first so no path leaves one unset
   always @* begin
      nxt_i_abort = 1'b0;
      nxt_i_cachable = 1'b0;
      nxt_d_abort = 1'b0;
      nxt_d_cachable = 1'b0;
      nxt_d_bufferable = 1'b0;
      nxt_d_cfg = 2'h0;
      if (pu_on) begin
         // prefetch abort on denial or miss
         nxt_i_abort = i_req_in & ~i_allow;
         nxt_i_cachable = i_any & icache_ff[i_win[2:0]];
         // data abort on denial or miss
         nxt_d_abort = d_req_in & ~d_allow;
         nxt_d_cachable = d_any & dcache_ff[d_win[2:0]];
         nxt_d_bufferable = d_any & buf_ff[d_win[2:0]];
         // four configurations from C and B
         nxt_d_cfg = {nxt_d_cachable, nxt_d_bufferable};
      end
   end

   // flag beats entering a new 4KB page; each beat checked on its own
   assign nxt_d_split = d_req_in & d_multi_in & last_multi_ff &
      (d_addr_in[31:`RPU_PAGE_BIT] != last_d_addr_ff[31:`RPU_PAGE_BIT]);

   // registered lookup results, one cycle after the request
   always @(posedge clk_in) begin
      if (rst_in) begin
         i_cachable_out <= 1'b0;
         i_abort_out <= 1'b0;
         d_cachable_out <= 1'b0;
         d_bufferable_out <= 1'b0;
         d_cfg_out <= 2'h0;
         d_abort_out <= 1'b0;
         d_split_out <= 1'b0;
         pu_enabled_out <= 1'b0;
      end else begin
         pu_enabled_out <= pu_on;
         i_cachable_out <= nxt_i_cachable;
         i_abort_out <= nxt_i_abort;
         d_cachable_out <= nxt_d_cachable;
         d_bufferable_out <= nxt_d_bufferable;
         d_cfg_out <= nxt_d_cfg;
         d_abort_out <= nxt_d_abort;
         d_split_out <= nxt_d_split;
      end
   end
endmodule

// ### tb/rpu_monitor.sv
// port assertions of the region protection unit
`include "rpu_regs.vh"
module rpu_monitor (
   input wire logic clk_in, // clock
   input wire logic rst_in, // reset
   input wire logic cp_wr_in, // write strobe
   input wire logic cp_rd_in, // read strobe
   input wire logic [3:0] cp_sel_in, // select
   input wire logic [31:0] cp_wdata_in, // write data
   input wire logic [31:0] cp_rdata_out, // read data
   input wire logic i_req_in, // fetch valid
   input wire logic d_req_in, // data valid
   input wire logic d_multi_in, // multi beat
   input wire logic i_abort_out, // prefetch abort
   input wire logic d_cachable_out, // data cachable
   input wire logic d_bufferable_out, // data bufferable
   input wire logic [1:0] d_cfg_out, // data config
   input wire logic d_abort_out, // data abort
   input wire logic d_split_out, // page crossing
   input wire logic pu_enabled_out // protection on
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);
   sequence s_ctrl_wr;
      cp_wr_in && cp_sel_in == `RPU_SEL_CTRL;
   endsequence
   // the flag may lag the control register a stage, so two off samples
   sequence s_off_twice;
      !pu_enabled_out ##1 !pu_enabled_out;
   endsequence
   // control register takes the write, the flag copies it one edge later
   property p_enable_follows;
      s_ctrl_wr |-> ##2 pu_enabled_out == $past(cp_wdata_in[`RPU_CTRL_PU_BIT], 2);
   endproperty
   a_enable_follows: assert property (p_enable_follows)
      else $error("enable did not follow control write");
   a_off_quiet: assert property (s_off_twice |-> !i_abort_out && !d_abort_out
      && d_cfg_out == 2'h0) else $error("attributes seen while protection off");
   a_fetch_abort_req: assert property (i_abort_out |-> $past(i_req_in))
      else $error("prefetch abort without fetch");
   a_data_abort_req: assert property (d_abort_out |-> $past(d_req_in))
      else $error("data abort without access");
   a_cfg_pair: assert property (d_cfg_out == {d_cachable_out, d_bufferable_out})
      else $error("config differs from cachable and bufferable");
   a_split_multi: assert property (d_split_out |-> $past(d_multi_in))
      else $error("split flagged on single access");
   a_region_unused: assert property (cp_rd_in && cp_sel_in == `RPU_SEL_REGION |=>
      cp_rdata_out[11:6] == 6'h0) else $error("unused region bits nonzero");
   a_reset_clear: assert property (disable iff (1'h0) rst_in |=> !pu_enabled_out
      && !d_abort_out && cp_rdata_out == 32'h0) else $error("outputs not cleared");
endmodule
bind rpu_top rpu_monitor u_mon (.*);

// ### tb/rpu_core_model.sv
// behavioural core issuing fetch and data addresses
module rpu_core_model (
   input wire logic clk_in, // clock
   output logic i_req_out, // fetch valid
   output logic [31:0] i_addr_out, // fetch address
   output logic i_priv_out, // fetch privileged
   output logic d_req_out, // data valid
   output logic [31:0] d_addr_out, // data address
   output logic d_write_out, // data write
   output logic d_priv_out, // data privileged
   output logic d_multi_out // multi beat
);
   timeunit 1ns;
   timeprecision 100ps;
   initial {i_req_out, i_addr_out, i_priv_out, d_req_out, d_addr_out} = '0;
   initial {d_write_out, d_priv_out, d_multi_out} = 3'h0;
   // one access per path, held until the edge that takes it
   task automatic issue(logic ir, logic [31:0] ia, logic ip, logic dr, logic [31:0] da,
      logic dw, logic dp, logic dm);
      {i_req_out, i_addr_out, i_priv_out} = {ir, ia, ip};
      {d_req_out, d_addr_out, d_write_out, d_priv_out, d_multi_out} = {dr, da, dw, dp, dm};
      @(posedge clk_in) #1;
   endtask
   // released address lines invert so stale values never pass for live ones
   task automatic idle;
      {i_req_out, d_req_out, d_multi_out} = 3'h0;
      i_addr_out = ~i_addr_out;
      d_addr_out = ~d_addr_out;
   endtask
endmodule

// ### tb/test_region_protection_unit.sv
// self-checking bench of the region protection unit
`include "rpu_regs.vh"
module test_region_protection_unit;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_in = 1'h0, rst_in = 1'h1, cp_wr_in = 1'h0, cp_rd_in = 1'h0, en, pv;
   logic [3:0] cp_sel_in = 4'h0;
   logic [2:0] cp_region_in = 3'h0;
   logic [31:0] cp_wdata_in = 32'h0, cp_rdata_out, i_addr_in, d_addr_in, dp, ip, a;
   logic i_req_in, i_priv_in, d_req_in, d_write_in, d_priv_in, d_multi_in, d_split_out;
   logic i_cachable_out, i_abort_out, d_cachable_out, d_bufferable_out, d_abort_out;
   logic pu_enabled_out;
   logic [1:0] d_cfg_out;
   logic [7:0] dc, ic, bf, r8;
   logic [19:0] pg;
   logic [31:0] rgn [8];
   int err_count = 0, cmp_count = 0;
   rpu_top DUT (.*);
   rpu_core_model core (.clk_in(clk_in), .i_req_out(i_req_in), .i_addr_out(i_addr_in),
      .i_priv_out(i_priv_in), .d_req_out(d_req_in), .d_addr_out(d_addr_in),
      .d_write_out(d_write_in), .d_priv_out(d_priv_in), .d_multi_out(d_multi_in));
   always #12.5 clk_in = ~clk_in;
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // register write, mirrored in the shadow copy
   task automatic wr(logic [3:0] sel, logic [2:0] r, logic [31:0] v);
      @(posedge clk_in) #1;
      {cp_sel_in, cp_region_in, cp_wdata_in, cp_wr_in} = {sel, r, v, 1'h1};
      @(posedge clk_in) #1;
      cp_wr_in = 1'h0;
      case (sel)
         `RPU_SEL_CTRL: en = v[`RPU_CTRL_PU_BIT];
         `RPU_SEL_DCACHE: dc = v[7:0];
         `RPU_SEL_ICACHE: ic = v[7:0];
         `RPU_SEL_BUF: bf = v[7:0];
         `RPU_SEL_DPERM: dp = v;
         `RPU_SEL_IPERM: ip = v;
         `RPU_SEL_REGION: rgn[r] = v & 32'hfffff03f;
         default: ;
      endcase
   endtask
   task automatic rd(logic [3:0] sel, logic [2:0] r, logic [31:0] exp);
      @(posedge clk_in) #1;
      {cp_sel_in, cp_region_in, cp_rd_in} = {sel, r, 1'h1};
      @(posedge clk_in) #1;
      cp_rd_in = 1'h0;
      check("cp_rdata_out", cp_rdata_out, exp);
   endtask
   // highest numbered enabled region whose masked base matches, -1 for none
   function automatic int win(logic [31:0] ad);
      logic [32:0] sz;
      win = -1;
      for (int r = 0; r < 8; r++) begin
         sz = 33'h2 << rgn[r][5:1];
         if (rgn[r][0] && ((ad ^ rgn[r]) & ~(sz[31:0] - 32'h1) & 32'hfffff000) == 32'h0)
            win = r;
      end
   endfunction
   function automatic logic allow(logic [3:0] c, logic prv, logic w);
      case (c)
         `RPU_AP_PRIV: allow = prv;
         `RPU_AP_PRIV_URO: allow = prv | ~w;
         `RPU_AP_FULL: allow = 1'h1;
         `RPU_AP_PRIV_RO: allow = prv & ~w;
         `RPU_AP_RO: allow = ~w;
         default: allow = 1'h0;
      endcase
   endfunction
   task automatic look(logic ir, logic [31:0] ia, logic ipv, logic dr, logic [31:0] da,
      logic dw, logic dpv, logic dm);
      int wi, wd;
      logic ix, dx;
      wi = win(ia);
      wd = win(da);
      ix = en && ir && (wi < 0 || !allow(ip[4*wi+:4], ipv, 1'h0));
      dx = en && dr && (wd < 0 || !allow(dp[4*wd+:4], dpv, dw));
      core.issue(ir, ia, ipv, dr, da, dw, dpv, dm && dr);
      check("i_abort_out", i_abort_out, ix);
      check("d_abort_out", d_abort_out, dx);
      if (ir && !ix)
         check("i_cachable_out", i_cachable_out, en && wi >= 0 && ic[wi]);
      if (dr && !dx) begin
         check("d_cfg_out", d_cfg_out, (en && wd >= 0) ? {dc[wd], bf[wd]} : 2'h0);
         check("d_cachable_out", d_cachable_out, en && wd >= 0 && dc[wd]);
         check("d_bufferable_out", d_bufferable_out, en && wd >= 0 && bf[wd]);
      end
      // page history follows every data beat taken, multi or not
      check("d_split_out", d_split_out, dm && dr && pv && da[31:12] != pg);
      if (dr)
         {pv, pg} = {dm, da[31:12]};
   endtask
   task automatic rand_looks(int n);
      repeat (n) begin
         r8 = $urandom;
         a = rgn[r8[7:5]] & 32'hfffff000 | $urandom % 32'h2000;
         look(r8[0], a, r8[1], r8[2], r8[3] ? a : $urandom, r8[4], $urandom, $urandom);
      end
   endtask
   initial begin
      #100us;
      err_count++;
      stop_test();
   end
   initial begin
      void'($urandom(32'h8e48));
      {en, pv, dc, ic, bf, dp, ip} = '0;
      rgn = '{default: 32'h0};
      repeat (8) @(posedge clk_in);
      #1 rst_in = 1'h0;
      for (int r = 0; r < 8; r++)
         rd(`RPU_SEL_REGION, r[2:0], 32'h0);
      $display("test reset done");
      // legal layout: code at least 4KB, base aligned, junk in unused bits
      for (int r = 0; r < 8; r++) begin
         r8 = 8'h0b + $urandom % 21;
         wr(`RPU_SEL_REGION, r[2:0], $urandom & ~((33'h2 << r8) - 33'h1) | $urandom & 32'hfc0
            | r8 << 1 | ($urandom % 4 != 0));
         rd(`RPU_SEL_REGION, r[2:0], rgn[r]);
      end
      for (int s = 2; s < 7; s++)
         wr(s[3:0], 3'h0, $urandom);
      rand_looks(40);
      $display("test disabled done");
      // regions exist before protection is switched on
      wr(`RPU_SEL_CTRL, 3'h0, 32'h1);
      rd(`RPU_SEL_CTRL, 3'h0, 32'h1);
      check("pu_enabled_out", pu_enabled_out, 1'h1);
      rand_looks(300);
      $display("test random done");
      for (int r = 0; r < 8; r++)
         wr(`RPU_SEL_REGION, r[2:0], 32'h0);
      // 16KB privileged region 1 under 4KB region 2 at 0x3000, then a miss
      wr(`RPU_SEL_REGION, 3'h1, 32'h1b);
      wr(`RPU_SEL_REGION, 3'h2, 32'h3017);
      wr(`RPU_SEL_DPERM, 3'h0, 32'h30000213);
      look(1'h0, 32'h0, 1'h0, 1'h1, 32'h3010, 1'h1, 1'h0, 1'h0);
      check("d_abort_out", d_abort_out, 1'h1);
      look(1'h0, 32'h0, 1'h0, 1'h1, 32'h3010, 1'h0, 1'h0, 1'h0);
      look(1'h0, 32'h0, 1'h0, 1'h1, 32'h0010, 1'h0, 1'h0, 1'h0);
      look(1'h0, 32'h0, 1'h0, 1'h1, 32'h8000, 1'h0, 1'h1, 1'h0);
      wr(`RPU_SEL_REGION, 3'h0, 32'h3f);
      look(1'h0, 32'h0, 1'h0, 1'h1, 32'h8000, 1'h0, 1'h0, 1'h0);
      $display("test overlap done");
      // size codes 11 to 31 on region 7 over the background, just inside and past the top
      wr(`RPU_SEL_BUF, 3'h0, 32'h0);
      wr(`RPU_SEL_DCACHE, 3'h0, 32'h80);
      wr(`RPU_SEL_IPERM, 3'h0, 32'h30000003);
      for (int c = 11; c < 32; c++) begin
         wr(`RPU_SEL_REGION, 3'h7, c[4:0] << 1 | 32'h1);
         a = (33'h2 << c) - 33'h4;
         look(1'h1, a, 1'h0, 1'h1, a, 1'h1, 1'h0, 1'h0);
         look(1'h1, a + 32'h4, 1'h1, 1'h1, a + 32'h4, 1'h0, 1'h1, 1'h0);
      end
      for (a = 32'hff8; a < 32'h1008; a += 32'h4)
         look(1'h0, 32'h0, 1'h0, 1'h1, a, 1'h0, 1'h1, 1'h1);
      wr(4'h0, 3'h0, 32'h0);
      rd(4'h8, 3'h0, 32'h0);
      wr(`RPU_SEL_CTRL, 3'h0, 32'h0);
      rand_looks(40);
      core.idle();
      $display("test misc done");
      stop_test();
   end
endmodule
